// [core/udcc_pkg.sv]
// Package of constants and types for the USB device config control block
package udcc_pkg;
   // Register map (byte addresses)
   localparam logic [7:0] UDCC_CFG0_OFF = 8'h00;  // usb_device_config_0
   localparam logic [7:0] UDCC_STAT_OFF = 8'h04;  // Live status word
   // Field positions in usb_device_config_0
   localparam int UDCC_SPEED_LSB = 13;
   localparam int UDCC_OVLP_BIT = 12;
   localparam int UDCC_U2X_BIT = 11;
   localparam int UDCC_TXRST_BIT = 10;
   localparam int UDCC_RXRST_BIT = 9;
   localparam int UDCC_SLP_BIT = 8;
   localparam int UDCC_BIR_BIT = 6;
   // Speed encodings
   localparam logic [2:0] UDCC_SPD_SS = 3'h4;
   localparam logic [2:0] UDCC_SPD_HS = 3'h0;
   localparam logic [2:0] UDCC_SPD_FS = 3'h1;
   // Reset values
   localparam logic [2:0] UDCC_SPEED_RST = 3'h4;
   localparam logic UDCC_OVLP_RST = 1'h0;
   localparam logic UDCC_U2X_RST = 1'h0;
   localparam logic UDCC_SLP_RST = 1'h1;
   localparam logic UDCC_BIR_RST = 1'h0;
   // LFPS filter times and cycle counts at 100 MHz
   localparam int UDCC_CLK_MHZ = 100;
   localparam int UDCC_SHORT_NS = 248;
   localparam int UDCC_LONG_US = 8;
   localparam int UDCC_SHORT_CYC = (UDCC_SHORT_NS * UDCC_CLK_MHZ + 999) / 1000;
   localparam int UDCC_LONG_CYC = UDCC_LONG_US * UDCC_CLK_MHZ;
   localparam int UDCC_CNT_W = 10;
   // Cycles a bulk pipe reset is held
   localparam logic [1:0] UDCC_PRST_CYC = 2'h2;
   // Exit handshake states
   typedef enum logic [3:0] {
      UDCC_X_IDLE = 4'h1,
      UDCC_X_FILT = 4'h2,
      UDCC_X_OVLP = 4'h4,
      UDCC_X_DONE = 4'h8
   } udcc_exit_type;
endpackage

// [core/udcc_top.sv]
// USB device config register with LFPS exit logic and bulk pipe resets
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Speed field 15:13 selects connect speed
// - Overlap check on: wait remote LFPS/TS
// - Overlap check off: finish exit immediately
// - Short U2 exit: 248ns LFPS suffices
// - Otherwise U2 exit needs 8us LFPS
// - Bit 10 write one resets bulk-in
// - Bit 9 write one resets bulk-out
// - Bit 8 gates L1 sleep/suspend
// - Empty FIFO IN token: ZLP or NAK
// - Overlap/U2 bits restore image on resets
// - Sleep enable restores image on resets
module udcc_top
   import udcc_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // AXI4-Lite write address / data / response
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Image values loaded from nonvolatile config, and reset events
   input wire logic img_ovlp_in,
   input wire logic img_u2x_in,
   input wire logic img_slp_in,
   input wire logic usb_reset_in,
   input wire logic lite_reset_request_in,
   // Link side (same clock domain)
   input wire logic lfps_in,
   input wire logic in_u2_in,
   input wire logic exit_start_in,
   input wire logic remote_seen_in,
   input wire logic in_l1_in,
   input wire logic in_token_in,
   input wire logic rx_fifo_empty_in,
   // Outputs to link, PHY and pipes
   output logic [2:0] connect_speed_select_out,
   output logic u2_exit_det_out,
   output logic exit_done_out,
   output logic phy_sleep_out,
   output logic bulk_in_transmitter_rst_out,
   output logic bulk_out_receiver_rst_out,
   output logic reply_zlp_out,
   output logic reply_nak_out
);

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [2:0] speed;
      logic ovlp;
      logic u2x;
      logic slp;
      logic empty_in_reply_select;
      logic [1:0] txcnt;       // Bulk-in reset hold counter
      logic [1:0] rxcnt;       // Bulk-out reset hold counter
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [UDCC_CNT_W-1:0] lfps_cnt;
      logic u2det;
      udcc_exit_type xst;
      logic zlp;
      logic nak;
      logic sleep;
   } udcc_state_type;

   udcc_state_type st_ff;
   udcc_state_type nxt_st;
   logic [UDCC_CNT_W-1:0] filt_len; // Active LFPS filter length
   logic [31:0] cfg_word;           // Readback of the config register
   logic [31:0] stat_word;          // Readback of live status

   ////////////////////////////////////////////////////////////////////////
   // Readback words; reserved bits read as zero
   always_comb begin
      cfg_word = 32'h0;
      cfg_word[UDCC_SPEED_LSB +: 3] = st_ff.speed;
      cfg_word[UDCC_OVLP_BIT] = st_ff.ovlp;
      cfg_word[UDCC_U2X_BIT] = st_ff.u2x;
      cfg_word[UDCC_TXRST_BIT] = (st_ff.txcnt != 2'h0);
      cfg_word[UDCC_RXRST_BIT] = (st_ff.rxcnt != 2'h0);
      cfg_word[UDCC_SLP_BIT] = st_ff.slp;
      cfg_word[UDCC_BIR_BIT] = st_ff.empty_in_reply_select;
      stat_word = {28'h0, st_ff.sleep, (st_ff.xst == UDCC_X_DONE),
                   (st_ff.xst == UDCC_X_OVLP), st_ff.u2det};
      // Filter length follows the short U2 exit bit
      filt_len = st_ff.u2x ? UDCC_CNT_W'(UDCC_SHORT_CYC)
                           : UDCC_CNT_W'(UDCC_LONG_CYC);
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      nxt_st = st_ff;
      // Pipe reset counters count down to zero by themselves
      if (st_ff.txcnt != 2'h0) begin
         nxt_st.txcnt = st_ff.txcnt - 2'h1;
      end
      if (st_ff.rxcnt != 2'h0) begin
         nxt_st.rxcnt = st_ff.rxcnt - 2'h1;
      end
      // Capture write address and data in either order
      if (s_axi_awvalid_in && s_axi_awready_out) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata_in;
         nxt_st.wstrb = s_axi_wstrb_in;
      end
      // Perform the write once both halves are held
      if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
         nxt_st.bvalid = 1'b1;
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bresp = 2'h0;
         if (st_ff.awaddr[7:2] == UDCC_CFG0_OFF[7:2]) begin
            if (st_ff.wstrb[1]) begin
               nxt_st.speed = st_ff.wdata[UDCC_SPEED_LSB +: 3];
               nxt_st.ovlp = st_ff.wdata[UDCC_OVLP_BIT];
               nxt_st.u2x = st_ff.wdata[UDCC_U2X_BIT];
               nxt_st.slp = st_ff.wdata[UDCC_SLP_BIT];
               if (st_ff.wdata[UDCC_TXRST_BIT]) begin
                  nxt_st.txcnt = UDCC_PRST_CYC;
               end
               if (st_ff.wdata[UDCC_RXRST_BIT]) begin
                  nxt_st.rxcnt = UDCC_PRST_CYC;
               end
            end
            if (st_ff.wstrb[0]) begin
               nxt_st.empty_in_reply_select = st_ff.wdata[UDCC_BIR_BIT];
            end
         end else if (st_ff.awaddr[7:2] != UDCC_STAT_OFF[7:2]) begin
            nxt_st.bresp = 2'h2; // Unmapped: SLVERR
         end
      end
      if (st_ff.bvalid && s_axi_bready_in) begin
         nxt_st.bvalid = 1'b0;
      end
      // Read: answer one cycle after the address is taken
      if (s_axi_arvalid_in && s_axi_arready_out) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = 2'h0;
         if (s_axi_araddr_in[7:2] == UDCC_CFG0_OFF[7:2]) begin
            nxt_st.rdata = cfg_word;
         end else if (s_axi_araddr_in[7:2] == UDCC_STAT_OFF[7:2]) begin
            nxt_st.rdata = stat_word;
         end else begin
            nxt_st.rdata = 32'h0;
            nxt_st.rresp = 2'h2;
         end
      end else if (st_ff.rvalid && s_axi_rready_in) begin
         nxt_st.rvalid = 1'b0;
      end
      // LFPS duration filter for U2 exit
      nxt_st.u2det = 1'b0;
      if (!lfps_in || !in_u2_in) begin
         nxt_st.lfps_cnt = '0;
      end else if (st_ff.lfps_cnt != filt_len) begin
         nxt_st.lfps_cnt = st_ff.lfps_cnt + UDCC_CNT_W'(1);
         // Glitches shorter than the filter never reach the detect
         nxt_st.u2det = (st_ff.lfps_cnt + UDCC_CNT_W'(1) == filt_len);
      end
      // Remote exit handshake
      case (st_ff.xst)
         UDCC_X_IDLE: begin
            if (exit_start_in) begin
               nxt_st.xst = st_ff.ovlp ? UDCC_X_OVLP : UDCC_X_DONE;
            end
         end
         UDCC_X_OVLP: begin
            // Guards against an LFPS glitch starting a false exit
            if (remote_seen_in) begin
               nxt_st.xst = UDCC_X_DONE;
            end
         end
         UDCC_X_DONE: begin
            nxt_st.xst = UDCC_X_IDLE;
         end
         default: begin
            nxt_st.xst = UDCC_X_IDLE;
         end
      endcase
      // Token reply and sleep output, registered
      nxt_st.zlp = in_token_in && rx_fifo_empty_in && !st_ff.empty_in_reply_select;
      nxt_st.nak = in_token_in && rx_fifo_empty_in && st_ff.empty_in_reply_select;
      nxt_st.sleep = in_l1_in && st_ff.slp;
      // USB or lite reset restores the image; a write in that cycle loses
      if (usb_reset_in || lite_reset_request_in) begin
         nxt_st.ovlp = img_ovlp_in;
         nxt_st.u2x = img_u2x_in;
         nxt_st.slp = img_slp_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '0;
         st_ff.speed <= UDCC_SPEED_RST;
         st_ff.ovlp <= UDCC_OVLP_RST;
         st_ff.u2x <= UDCC_U2X_RST;
         st_ff.slp <= UDCC_SLP_RST;
         st_ff.empty_in_reply_select <= UDCC_BIR_RST;
         st_ff.xst <= UDCC_X_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign s_axi_awready_out = !st_ff.aw_got;
   assign s_axi_wready_out = !st_ff.w_got;
   assign s_axi_bvalid_out = st_ff.bvalid;
   assign s_axi_bresp_out = st_ff.bresp;
   assign s_axi_arready_out = !st_ff.rvalid;
   assign s_axi_rvalid_out = st_ff.rvalid;
   assign s_axi_rdata_out = st_ff.rdata;
   assign s_axi_rresp_out = st_ff.rresp;
   assign connect_speed_select_out = st_ff.speed;
   assign u2_exit_det_out = st_ff.u2det;
   assign exit_done_out = (st_ff.xst == UDCC_X_DONE);
   assign phy_sleep_out = st_ff.sleep;
   assign bulk_in_transmitter_rst_out = (st_ff.txcnt != 2'h0);
   assign bulk_out_receiver_rst_out = (st_ff.rxcnt != 2'h0);
   assign reply_zlp_out = st_ff.zlp;
   assign reply_nak_out = st_ff.nak;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   tx_selfclear_a: assert property ($rose(bulk_in_transmitter_rst_out)
      |-> bulk_in_transmitter_rst_out [*2] ##1 !bulk_in_transmitter_rst_out)
      else $error("bulk-in reset not two cycles");
   rx_selfclear_a: assert property ($rose(bulk_out_receiver_rst_out)
      |-> bulk_out_receiver_rst_out [*2] ##1 !bulk_out_receiver_rst_out)
      else $error("bulk-out reset not two cycles");
   ovlp_wait_a: assert property (st_ff.xst == UDCC_X_OVLP && !remote_seen_in
      |=> !exit_done_out) else $error("exit done without remote");
   no_ovlp_a: assert property (st_ff.xst == UDCC_X_IDLE && exit_start_in && !st_ff.ovlp
      |=> exit_done_out) else $error("exit not immediate");
   // Detect must come on the 25th LFPS cycle, the count then standing one short of it
   short_filt_a: assert property (u2_exit_det_out && st_ff.u2x |->
      $past(st_ff.lfps_cnt) == 10'h018) else $error("short filter count wrong");
   long_det_a: assert property (u2_exit_det_out && !st_ff.u2x |->
      $past(st_ff.lfps_cnt) == 10'h31F) else $error("long filter early");
   sleep_gate_a: assert property (phy_sleep_out |-> $past(st_ff.slp) && $past(in_l1_in))
      else $error("sleep without enable");
   reply_sel_a: assert property (in_token_in && rx_fifo_empty_in |=>
      (reply_nak_out == $past(st_ff.empty_in_reply_select)) && (reply_zlp_out != reply_nak_out))
      else $error("wrong empty reply");
   image_rest_a: assert property (usb_reset_in |=> st_ff.slp == $past(img_slp_in)
      && st_ff.ovlp == $past(img_ovlp_in)) else $error("image not restored");
   // Lite reset must reload the filter and overlap bits just as USB reset does
   lite_rest_a: assert property (lite_reset_request_in |=> st_ff.u2x == $past(img_u2x_in)
      && st_ff.ovlp == $past(img_ovlp_in)) else $error("lite image not restored");
   // The speed pins move only with an accepted write to the config word
   speed_out_a: assert property (!$stable(connect_speed_select_out) |->
      $rose(s_axi_bvalid_out) && s_axi_bresp_out == 2'h0)
      else $error("speed output changed without write");

   // Main scenarios the bench is expected to reach
   exit_ovlp_c: cover property (st_ff.xst == UDCC_X_OVLP ##1 exit_done_out);
   u2_short_c: cover property (u2_exit_det_out && st_ff.u2x);
   nak_c: cover property (reply_nak_out);
   txrst_c: cover property ($rose(bulk_in_transmitter_rst_out));

endmodule
`default_nettype wire

// [sim/udcc_host_model.sv]
// Behavioural USB host and link partner facing the link side of the block
`timescale 1ns/1ps
`default_nettype none
module udcc_host_model (
   // Clock
   input wire logic clk_in,
   // Link levels and pulses towards the block
   output logic lfps_out,
   output logic in_u2_out,
   output logic exit_start_out,
   output logic remote_seen_out,
   output logic in_l1_out,
   output logic in_token_out,
   output logic rx_fifo_empty_out
);
   // Quiet link at time zero; FIFO idles empty
   initial begin
      {lfps_out, in_u2_out, exit_start_out, remote_seen_out, in_l1_out, in_token_out} = 6'h0;
      rx_fifo_empty_out = 1'h1;
   end
   // LFPS for n cycles while parked in U2, then the line goes quiet again
   task automatic lfps_burst(input int n);
      @(posedge clk_in);
      {lfps_out, in_u2_out} <= 2'h3;
      repeat (n) @(posedge clk_in);
      {lfps_out, in_u2_out} <= 2'h0;
   endtask
   // One-cycle remote exit start
   task automatic exit_begin;
      @(posedge clk_in);
      exit_start_out <= 1'h1;
      @(posedge clk_in);
      exit_start_out <= 1'h0;
   endtask
   // Remote LFPS seen for one cycle; it is held back so a slow host can be shown
   task automatic remote_answer;
      @(posedge clk_in);
      remote_seen_out <= 1'h1;
      @(posedge clk_in);
      remote_seen_out <= 1'h0;
   endtask
   // Bulk-in token with the FIFO state it meets
   task automatic in_token(input logic empty);
      @(posedge clk_in);
      {in_token_out, rx_fifo_empty_out} <= {1'h1, empty};
      @(posedge clk_in);
      {in_token_out, rx_fifo_empty_out} <= 2'h1;
   endtask
   // Link power state L1
   task automatic set_l1(input logic v);
      @(posedge clk_in);
      in_l1_out <= v;
   endtask
endmodule
`default_nettype wire

// [sim/udcc_top_test.sv]
// Self-checking bench for the USB device config control block
`timescale 1ns/1ps
`default_nettype none
module udcc_top_test;
   import udcc_pkg::*;
   // Bus and reset driven by the bench
   logic clk_in, arst_n_in, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rr, br;
   logic awready, wready, bvalid, arready, rvalid;
   // Image bits and reset events
   logic img_ovlp, img_u2x, img_slp, usb_rst, lite_rst;
   // Link wires from the partner and block outputs
   logic lfps, in_u2, ex_start, remote, in_l1, token, fifo_empty;
   logic [2:0] speed;
   logic det, done, sleep, tx_rst, rx_rst, zlp, nak;
   // Tallies
   int miscompares = 0, comparisons = 0;
   int det_n = 0, done_n = 0, tx_n = 0, rx_n = 0, zlp_n = 0, nak_n = 0;
   int k0, k1;
   udcc_top udcc_top_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .img_ovlp_in(img_ovlp),
      .img_u2x_in(img_u2x), .img_slp_in(img_slp), .usb_reset_in(usb_rst),
      .lite_reset_request_in(lite_rst), .lfps_in(lfps), .in_u2_in(in_u2),
      .exit_start_in(ex_start), .remote_seen_in(remote), .in_l1_in(in_l1),
      .in_token_in(token), .rx_fifo_empty_in(fifo_empty),
      .connect_speed_select_out(speed), .u2_exit_det_out(det), .exit_done_out(done),
      .phy_sleep_out(sleep), .bulk_in_transmitter_rst_out(tx_rst),
      .bulk_out_receiver_rst_out(rx_rst), .reply_zlp_out(zlp), .reply_nak_out(nak));
   udcc_host_model udcc_host_model_i (.clk_in(clk_in), .lfps_out(lfps), .in_u2_out(in_u2),
      .exit_start_out(ex_start), .remote_seen_out(remote), .in_l1_out(in_l1),
      .in_token_out(token), .rx_fifo_empty_out(fifo_empty));
   // 100 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Tally pulses at the falling edge, where outputs have settled
   always @(negedge clk_in) begin
      det_n += int'(det === 1'b1);
      done_n += int'(done === 1'b1);
      tx_n += int'(tx_rst === 1'b1);
      rx_n += int'(rx_rst === 1'b1);
      zlp_n += int'(zlp === 1'b1);
      nak_n += int'(nak === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
         miscompares++;
      end
   endtask
   // A hung handshake ends the run
   task automatic guard(input int n);
      if (n > 100) begin
         miscompares++;
         close_out();
      end
   endtask
   // Write: address and data offered together, each dropped when taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge clk_in);
         n++;
         guard(n);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      br = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk_in);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge clk_in);
         n++;
         guard(n);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   // Config word from its fields
   function automatic logic [31:0] cfg(input logic [2:0] s, input logic o, u, sl, e);
      return (32'(s) << 13) | (32'(o) << 12) | (32'(u) << 11) | (32'(sl) << 8) | (32'(e) << 6);
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // Reset values, every speed code and an unmapped read
   task automatic t_regs;
      logic [2:0] codes [3] = '{3'h4, 3'h0, 3'h1};
      axi_read(8'h00);
      chk("cfg reset", cfg(3'h4, 0, 0, 1, 0), rd);
      foreach (codes[i]) begin
         axi_write(8'h00, cfg(codes[i], 0, 0, 1, 0));
         chk("write resp", 0, br);
         axi_read(8'h00);
         chk("cfg speed", cfg(codes[i], 0, 0, 1, 0), rd);
         chk("speed pins", codes[i], speed);
      end
      axi_read(8'h08);
      chk("unmapped resp", 2, rr);
      axi_write(8'h08, 32'h0);
      chk("unmapped bresp", 2, br);
   endtask
   // USB reset then lite reset reload the image bits
   task automatic t_image;
      @(posedge clk_in);
      {img_ovlp, img_u2x, img_slp, usb_rst} <= 4'hD;
      @(posedge clk_in);
      usb_rst <= 1'b0;
      axi_read(8'h00);
      chk("image usb", 32'h1800, rd & 32'h1900);
      {img_ovlp, img_u2x, img_slp, lite_rst} <= 4'h3;
      @(posedge clk_in);
      lite_rst <= 1'b0;
      axi_read(8'h00);
      chk("image lite", 32'h0100, rd & 32'h1900);
   endtask
   // Short and long U2 exit filters, a glitch below each
   task automatic t_u2(input logic u, input int lo, input int hi);
      axi_write(8'h00, cfg(3'h4, 0, u, 1, 0));
      k0 = det_n;
      udcc_host_model_i.lfps_burst(lo);
      repeat (4) @(posedge clk_in);
      chk("u2 glitch", 0, det_n - k0);
      udcc_host_model_i.lfps_burst(hi);
      repeat (4) @(posedge clk_in);
      chk("u2 exit", 1, det_n - k0);
   endtask
   // Remote exit with overlap check off, then on with a slow host
   task automatic t_exit;
      axi_write(8'h00, cfg(3'h4, 0, 0, 1, 0));
      k0 = done_n;
      udcc_host_model_i.exit_begin();
      repeat (3) @(posedge clk_in);
      chk("exit plain", 1, done_n - k0);
      axi_write(8'h00, cfg(3'h4, 1, 0, 1, 0));
      udcc_host_model_i.exit_begin();
      repeat (20) @(posedge clk_in);
      chk("exit waits", 1, done_n - k0);
      udcc_host_model_i.remote_answer();
      repeat (3) @(posedge clk_in);
      chk("exit overlap", 2, done_n - k0);
   endtask
   // Pipe reset bits pulse their reset and clear themselves
   task automatic t_pipe(input int b);
      k0 = tx_n;
      k1 = rx_n;
      axi_write(8'h00, cfg(3'h4, 0, 0, 1, 0) | (32'h1 << b));
      repeat (6) @(posedge clk_in);
      chk("tx reset", (b == 10) ? 2 : 0, tx_n - k0);
      chk("rx reset", (b == 9) ? 2 : 0, rx_n - k1);
      axi_read(8'h00);
      chk("self clear", cfg(3'h4, 0, 0, 1, 0), rd);
   endtask
   // Sleep gate in L1; the only test that writes bit 8 as zero
   task automatic t_sleep;
      udcc_host_model_i.set_l1(1'b1);
      repeat (3) @(posedge clk_in);
      chk("sleep on", 1, sleep);
      axi_read(8'h04);
      chk("stat sleep", 32'h8, rd);
      axi_write(8'h00, cfg(3'h4, 0, 0, 0, 0));
      repeat (3) @(posedge clk_in);
      chk("sleep off", 0, sleep);
      udcc_host_model_i.set_l1(1'b0);
   endtask
   // Reply to IN tokens: each select value, then a FIFO with data
   task automatic t_token(input logic e, input logic empty);
      axi_write(8'h00, cfg(3'h4, 0, 0, 1, e));
      k0 = zlp_n;
      k1 = nak_n;
      udcc_host_model_i.in_token(empty);
      repeat (3) @(posedge clk_in);
      chk("zlp", empty & ~e, zlp_n - k0);
      chk("nak", empty & e, nak_n - k1);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {arst_n_in, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata} = 48'h0;
      {img_ovlp, img_u2x, img_slp, usb_rst, lite_rst} = 5'h0;
      repeat (20) @(posedge clk_in);
      arst_n_in <= 1'b1;
      t_regs();
      t_image();
      t_u2(1'b1, 22, 26);
      t_u2(1'b0, 400, 802);
      t_exit();
      t_pipe(10);
      t_pipe(9);
      t_sleep();
      t_token(1'b0, 1'b1);
      t_token(1'b1, 1'b1);
      t_token(1'b1, 1'b0);
      close_out();
   end
endmodule
`default_nettype wire
